// file: ufc_host.sv
// module: host-side command sequencer for frequency set and erase commands
`timescale 1ns/100ps
module ufc_host #(
  parameter int GAP_CYC     = ufc_pkg::COM_GAP_CYC,
  parameter int FREQ_TO_CYC = ufc_pkg::FREQ_TO_MS * ufc_pkg::CYC_PER_MS,
  parameter int CHIP_TO_CYC = ufc_pkg::CHIP_TO_MS * ufc_pkg::CYC_PER_MS,
  parameter int BLK_TO_CYC  = ufc_pkg::BLK_TO_MS * ufc_pkg::CYC_PER_MS,
  parameter int DIV_SLOW    = ufc_pkg::DIV_SLOW,
  parameter int DIV_FAST    = ufc_pkg::DIV_FAST
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // command request
  input  wire logic             req_valid,
  input  wire ufc_pkg::ufc_req_t req,
  output logic                  busy,
  // command answer
  output logic                  done,
  output ufc_pkg::ufc_rsp_t     rsp,
  output logic                  fast_rate,
  // serial link
  output logic                  txd,
  input  wire logic             rxd
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ufc_pkg::ufc_state_t st;
    ufc_pkg::ufc_op_t    op;
    logic [31:0] cnt;
    logic [31:0] tmo;
    // outgoing frame, SOH through ETX
    logic [10:0][7:0] buf_b;
    logic [3:0]  nbytes;
    logic [3:0]  idx;
    logic        fast;
    logic        busy;
    logic        done;
    ufc_pkg::ufc_rsp_t rsp;
    // transmitter
    logic [15:0] tdiv;
    logic [3:0]  tbit;
    logic [9:0]  tsh;
    logic        tact;
    logic        txd;
    // receiver
    logic [15:0] rdiv;
    logic [3:0]  rbit;
    logic [7:0]  rsh;
    logic        ract;
    logic [2:0]  rpos;
    logic [7:0]  rcode;
    logic [7:0]  rsum;
  } ufc_s_t;
  ufc_s_t     s_r;
  ufc_s_t     s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [1:0] rx_sync_r;
  logic       rx;
  // ************************************************************
  // reset release and pin synchroniser
  // ************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_r <= 2'h3;
    end else if (clk_en) begin
      rx_sync_r <= {rx_sync_r[0], rxd};
    end
  end
  assign rx = rx_sync_r[1];
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [31:0] div;
    logic [7:0]  sum;
    logic [7:0]  nblk;
    logic        rx_byte;
    logic [7:0]  rb;
    s_nxt   = s_r;
    div     = s_r.fast ? 32'(DIV_FAST) : 32'(DIV_SLOW);
    sum     = 8'h00;
    nblk    = 8'h00;
    rx_byte = 1'b0;
    rb      = 8'h00;
    s_nxt.done = 1'b0;
    // uart transmitter
    if (s_r.tact) begin
      if (s_r.tdiv == 16'h0000) begin
        s_nxt.txd  = s_r.tsh[0];
        s_nxt.tsh  = {1'b1, s_r.tsh[9:1]};
        s_nxt.tdiv = 16'(div - 32'd1);
        if (s_r.tbit == 4'hA) begin
          s_nxt.tact = 1'b0;
          s_nxt.txd  = 1'b1;
        end
        s_nxt.tbit = s_r.tbit + 4'h1;
      end else begin
        s_nxt.tdiv = s_r.tdiv - 16'h0001;
      end
    end
    // uart receiver, sampled mid-bit
    if (!s_r.ract) begin
      if (!rx) begin
        s_nxt.ract = 1'b1;
        // start is seen late through the synchroniser; trim that lag
        // so every bit is sampled mid-bit (divider must be 4 or more)
        s_nxt.rdiv = 16'((div >> 1) - 32'(ufc_pkg::RX_SYNC_LAT));
        s_nxt.rbit = 4'h0;
      end
    end else if (s_r.rdiv == 16'h0000) begin
      s_nxt.rdiv = 16'(div - 32'd1);
      s_nxt.rbit = s_r.rbit + 4'h1;
      if (s_r.rbit == 4'h0 && rx) begin
        s_nxt.ract = 1'b0;
      end else if (s_r.rbit >= 4'h1 && s_r.rbit <= 4'h8) begin
        s_nxt.rsh = {rx, s_r.rsh[7:1]};
      end else if (s_r.rbit == 4'h9) begin
        s_nxt.ract = 1'b0;
        rx_byte    = rx;
        rb         = s_r.rsh;
      end
    end else begin
      s_nxt.rdiv = s_r.rdiv - 16'h0001;
    end
    // command sequencer
    case (s_r.st)
      ufc_pkg::ST_IDLE: begin
        // requests are taken only here, so one while busy is ignored
        if (req_valid) begin
          s_nxt.op   = req.op;
          s_nxt.busy = 1'b1;
          s_nxt.buf_b[0] = ufc_pkg::SOH_BYTE;
          case (req.op)
            ufc_pkg::OP_FREQ: begin
              s_nxt.buf_b[1] = ufc_pkg::LEN_FREQ;
              s_nxt.buf_b[2] = ufc_pkg::CMD_FREQ_SET;
              s_nxt.buf_b[3] = req.freq[31:24];
              s_nxt.buf_b[4] = req.freq[23:16];
              s_nxt.buf_b[5] = req.freq[15:8];
              s_nxt.buf_b[6] = req.freq[7:0];
              s_nxt.nbytes   = 4'h9;
              s_nxt.tmo      = 32'(FREQ_TO_CYC);
            end
            ufc_pkg::OP_CHIP: begin
              s_nxt.buf_b[1] = ufc_pkg::LEN_CHIP;
              s_nxt.buf_b[2] = ufc_pkg::CMD_CHIP_ERS;
              s_nxt.nbytes   = 4'h5;
              s_nxt.tmo      = 32'(CHIP_TO_CYC);
            end
            default: begin
              s_nxt.buf_b[1] = ufc_pkg::LEN_BLK;
              s_nxt.buf_b[2] = ufc_pkg::CMD_BLK_ERS;
              s_nxt.buf_b[3] = req.sblk; // block addressing, 64 KiB steps
              s_nxt.buf_b[4] = 8'h00;
              s_nxt.buf_b[5] = 8'h00;
              s_nxt.buf_b[6] = req.eblk;
              s_nxt.buf_b[7] = 8'hFF;
              s_nxt.buf_b[8] = 8'hFF;
              s_nxt.nbytes   = 4'hB;
              nblk = req.eblk - req.sblk;
              s_nxt.tmo = 32'(BLK_TO_CYC) * (32'(nblk) + 32'd1);
            end
          endcase
          // reversed range refused before any frame goes out
          if (req.op == ufc_pkg::OP_BLK && req.sblk > req.eblk) begin
            s_nxt.busy     = 1'b0;
            s_nxt.done     = 1'b1;
            s_nxt.rsp.res  = ufc_pkg::RES_BADARG;
            s_nxt.rsp.code = 8'h00;
          end else begin
            s_nxt.st  = ufc_pkg::ST_GAP;
            s_nxt.cnt = 32'd0;
          end
        end
      end
      ufc_pkg::ST_GAP: begin
        // checksum: two's complement of LEN..params
        for (int i = 1; i < 9; i++) begin
          if (4'(i) < s_r.nbytes - 4'h2) begin
            sum = sum - s_r.buf_b[i];
          end
        end
        s_nxt.buf_b[s_r.nbytes - 4'h2] = sum;
        s_nxt.buf_b[s_r.nbytes - 4'h1] = ufc_pkg::ETX_BYTE;
        s_nxt.cnt = s_r.cnt + 32'd1;
        if (s_r.cnt >= 32'(GAP_CYC)) begin
          s_nxt.st  = ufc_pkg::ST_SEND;
          s_nxt.idx = 4'h0;
        end
      end
      ufc_pkg::ST_SEND: begin
        if (!s_r.tact) begin
          if (s_r.idx == s_r.nbytes) begin
            s_nxt.st   = ufc_pkg::ST_WAIT;
            s_nxt.cnt  = 32'd0;
            s_nxt.rpos = 3'h0;
          end else begin
            s_nxt.tact = 1'b1;
            s_nxt.tsh  = {1'b1, s_r.buf_b[s_r.idx], 1'b0};
            s_nxt.tdiv = 16'h0000;
            s_nxt.tbit = 4'h0;
            s_nxt.idx  = s_r.idx + 4'h1;
          end
        end
      end
      ufc_pkg::ST_WAIT: begin
        s_nxt.cnt = s_r.cnt + 32'd1;
        // a status frame with bad length or sum is dropped, wait runs on
        if (rx_byte) begin
          case (s_r.rpos)
            3'h0: if (rb == ufc_pkg::STX_BYTE) s_nxt.rpos = 3'h1;
            3'h1: begin
              s_nxt.rpos = (rb == ufc_pkg::STAT_LEN) ? 3'h2 : 3'h0;
              s_nxt.rsum = 8'h00 - rb;
            end
            3'h2: begin
              s_nxt.rcode = rb;
              s_nxt.rsum  = s_r.rsum - rb;
              s_nxt.rpos  = 3'h3;
            end
            3'h3: s_nxt.rpos = (rb == s_r.rsum) ? 3'h4 : 3'h0;
            default: begin
              s_nxt.rpos = 3'h0;
              if (rb == ufc_pkg::ETX_BYTE) begin
                s_nxt.st       = ufc_pkg::ST_DONE;
                s_nxt.rsp.code = s_r.rcode;
                s_nxt.rsp.res  = (s_r.rcode == ufc_pkg::ST_ACK) ?
                                 ufc_pkg::RES_OK : ufc_pkg::RES_ABN;
                if (s_r.op == ufc_pkg::OP_FREQ) begin
                  s_nxt.fast = 1'b1;
                end
              end
            end
          endcase
        end else if (s_r.cnt >= s_r.tmo) begin
          s_nxt.st       = ufc_pkg::ST_DONE;
          s_nxt.rsp.res  = ufc_pkg::RES_TIMEOUT;
          s_nxt.rsp.code = 8'h00;
        end
      end
      ufc_pkg::ST_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st   = ufc_pkg::ST_IDLE;
      end
      default: s_nxt.st = ufc_pkg::ST_IDLE;
    endcase
  end
  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r     <= '0;
      s_r.txd <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end
  assign busy      = s_r.busy;
  assign done      = s_r.done;
  assign rsp       = s_r.rsp;
  assign fast_rate = s_r.fast;
  assign txd       = s_r.txd;
endmodule

// file: ufc_pkg.sv
// package: constants and carrier types for the flash-programmer command host
package ufc_pkg;
  // ************************************************************
  // frame bytes and status codes
  // ************************************************************
  localparam logic [7:0] SOH_BYTE      = 8'h01;
  localparam logic [7:0] STX_BYTE      = 8'h02;
  localparam logic [7:0] ETX_BYTE      = 8'h03;
  localparam logic [7:0] ST_ACK        = 8'h06;
  localparam logic [7:0] ST_PARAM_ERR  = 8'h05;
  localparam logic [7:0] ST_SUM_ERR    = 8'h07;
  localparam logic [7:0] ST_PROT_ERR   = 8'h10;
  localparam logic [7:0] ST_NACK       = 8'h15;
  localparam logic [7:0] ST_ERASE_ERR  = 8'h1A;
  localparam logic [7:0] STAT_LEN      = 8'h01;
  // command codes are not given here; neutral defaults
  localparam logic [7:0] CMD_FREQ_SET  = 8'h90;
  localparam logic [7:0] CMD_CHIP_ERS  = 8'h20;
  localparam logic [7:0] CMD_BLK_ERS   = 8'h22;
  // command field lengths
  localparam logic [7:0] LEN_FREQ      = 8'h05;
  localparam logic [7:0] LEN_CHIP      = 8'h01;
  localparam logic [7:0] LEN_BLK       = 8'h07;
  localparam logic [7:0] BLK_MAX       = 8'hFF;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int BAUD_SLOW    = 9_600;
  localparam int BAUD_FAST    = 115_200;
  localparam int DIV_SLOW     = CLK_HZ / BAUD_SLOW;
  localparam int DIV_FAST     = CLK_HZ / BAUD_FAST;
  localparam int COM_GAP_US   = 1_000;
  localparam int COM_GAP_CYC  = COM_GAP_US * (CLK_HZ / 1_000_000);
  localparam int FREQ_TO_MS   = 100;
  localparam int CHIP_TO_MS   = 1_000;
  localparam int BLK_TO_MS    = 100;
  localparam int CYC_PER_MS   = CLK_HZ / 1_000;
  localparam int RX_SYNC_LAT  = 2;
  // ************************************************************
  // states and carriers
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GAP  = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } ufc_state_t;
  typedef enum logic [1:0] {
    OP_FREQ = 2'b00,
    OP_CHIP = 2'b01,
    OP_BLK  = 2'b10
  } ufc_op_t;
  typedef enum logic [1:0] {
    RES_OK      = 2'b00,
    RES_ABN     = 2'b01,
    RES_TIMEOUT = 2'b10,
    RES_BADARG  = 2'b11
  } ufc_res_t;
  typedef struct packed {
    ufc_op_t     op;
    logic [31:0] freq;
    logic [7:0]  sblk;
    logic [7:0]  eblk;
  } ufc_req_t;
  typedef struct packed {
    ufc_res_t   res;
    logic [7:0] code;
  } ufc_rsp_t;
endpackage

// file: ufc_host_chk.sv
// checker: port-level assertions for the command host
`timescale 1ns/100ps
module ufc_host_chk (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              clk_en,
  // command request and answer
  input wire logic              req_valid,
  input wire ufc_pkg::ufc_req_t req,
  input wire logic              busy,
  input wire logic              done,
  input wire ufc_pkg::ufc_rsp_t rsp,
  input wire logic              fast_rate,
  // serial link
  input wire logic              txd,
  input wire logic              rxd
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ************************************************************
  // sequences and properties
  // ************************************************************
  sequence s_take;
    !busy && req_valid && clk_en ##1 busy;
  endsequence
  sequence s_bad_blk;
    !busy && req_valid && clk_en && req.op == ufc_pkg::OP_BLK &&
      req.sblk > req.eblk;
  endsequence
  AST_GAP: assert property (s_take |-> txd [*8])
    else $error("line left idle too early");
  AST_IDLE_LINE: assert property (!busy |-> txd)
    else $error("line not idle high");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(busy) |-> done)
    else $error("busy dropped without done");
  AST_FAST_STICKY: assert property (fast_rate |=> fast_rate)
    else $error("fast rate lost");
  AST_FAST_CAUSE: assert property ($rose(fast_rate) |-> ##[0:2] done)
    else $error("fast rate without answer");
  AST_ABN_CODE: assert property (done && rsp.res == ufc_pkg::RES_ABN
    |-> rsp.code != ufc_pkg::ST_ACK)
    else $error("ack reported abnormal");
  AST_OK_CODE: assert property (done && rsp.res == ufc_pkg::RES_OK
    |-> rsp.code == ufc_pkg::ST_ACK)
    else $error("non-ack reported ok");
  AST_BADARG: assert property (s_bad_blk |-> ##[1:2]
    (done && rsp.res == ufc_pkg::RES_BADARG))
    else $error("bad block range not refused");
  AST_RSP_STAND: assert property ($changed(rsp) |-> ##[0:1] done)
    else $error("answer changed without done");
endmodule
bind ufc_host ufc_host_chk ufc_host_chk_inst (.sys_clk(sys_clk),
  .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
  .busy(busy), .done(done), .rsp(rsp), .fast_rate(fast_rate), .txd(txd),
  .rxd(rxd));

// file: ufc_dev_model.sv
// model: device end that decodes command frames and sends status frames
`timescale 1ns/100ps
module ufc_dev_model #(
  parameter int DIV_SLOW = 8,
  parameter int DIV_FAST = 4
) (
  // link
  input wire logic         sys_clk,
  input wire logic         line_in,
  output logic             line_out,
  // control and capture
  input wire logic [7:0]   st_code,
  input wire logic         silent,
  output logic [7:0]       cap_len,
  output logic [7:0]       cap_cmd,
  output logic [47:0]      cap_pay
);
  logic fast = 1'b0;
  task automatic rx(output logic [7:0] b);
    @(negedge line_in);
    repeat ((fast ? DIV_FAST : DIV_SLOW) / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (fast ? DIV_FAST : DIV_SLOW) @(posedge sys_clk);
      if (i < 8) b[i] = line_in;
    end
  endtask
  task automatic tx(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (fast ? DIV_FAST : DIV_SLOW) @(posedge sys_clk);
    end
  endtask
  initial begin
    logic [7:0] b, len, cmd, sum, st;
    logic [47:0] pay;
    line_out = 1'b1;
    forever begin
      b = 8'h00;
      while (b !== ufc_pkg::SOH_BYTE) rx(b);
      rx(len);
      rx(cmd);
      sum = len + cmd;
      pay = '0;
      for (int i = 1; i < 32'(len); i++) begin
        rx(b);
        pay = {pay[39:0], b};
        sum = sum + b;
      end
      rx(b);
      sum = sum + b;
      rx(b);
      st = st_code;
      if (b !== ufc_pkg::ETX_BYTE) st = ufc_pkg::ST_NACK;
      if (sum !== 8'h00) st = ufc_pkg::ST_SUM_ERR;
      cap_len = len;
      cap_cmd = cmd;
      cap_pay = pay;
      if (!silent) begin
        repeat (20) @(posedge sys_clk);
        tx(ufc_pkg::STX_BYTE);
        tx(ufc_pkg::STAT_LEN);
        tx(st);
        tx(8'h00 - (ufc_pkg::STAT_LEN + st));
        tx(ufc_pkg::ETX_BYTE);
        if (cmd === ufc_pkg::CMD_FREQ_SET) fast = 1'b1;
      end
    end
  end
endmodule

// file: ufc_host_tb.sv
// testbench: command host against the device model
`timescale 1ns/100ps
module ufc_host_tb;
  localparam int TO = 2000;
  logic              sys_clk, nrst, req_valid, busy, done, fast_rate;
  logic              txd, rxd, silent, clk_en;
  ufc_pkg::ufc_req_t req;
  ufc_pkg::ufc_rsp_t rsp, r;
  logic [7:0]        st_code, cap_len, cap_cmd;
  logic [47:0]       cap_pay;
  int                mismatches, n_compared, t;
  int                cyc = 0;
  ufc_host #(.GAP_CYC(10), .FREQ_TO_CYC(TO), .CHIP_TO_CYC(TO),
    .BLK_TO_CYC(TO), .DIV_SLOW(8), .DIV_FAST(4)) ufc_host_inst (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .busy(busy), .done(done), .rsp(rsp),
    .fast_rate(fast_rate), .txd(txd), .rxd(rxd));
  ufc_dev_model #(.DIV_SLOW(8), .DIV_FAST(4)) ufc_dev_model_inst (
    .sys_clk(sys_clk), .line_in(txd), .line_out(rxd), .st_code(st_code),
    .silent(silent), .cap_len(cap_len), .cap_cmd(cap_cmd),
    .cap_pay(cap_pay));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_rsp(input ufc_pkg::ufc_rsp_t got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [47:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input ufc_pkg::ufc_op_t op, input logic [31:0] f,
                     input logic [7:0] s, e);
    @(negedge sys_clk);
    req = {op, f, s, e};
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    t = 0;
    // a hang is caught by the cycle ceiling
    while (done !== 1'b1) begin
      @(negedge sys_clk);
      t++;
    end
    r = rsp;
  endtask
  function automatic ufc_pkg::ufc_rsp_t exp_of(input logic [7:0] c);
    return {(c == 8'h06) ? ufc_pkg::RES_OK : ufc_pkg::RES_ABN, c};
  endfunction
  task automatic t_chip();
    logic [7:0] c[4] = '{8'h06, 8'h10, 8'h1A, 8'h15};
    foreach (c[i]) begin
      st_code = c[i];
      run(ufc_pkg::OP_CHIP, 32'h0, 8'h00, 8'h00);
      chk_rsp(r, exp_of(c[i]));
      chk_val({32'h0, cap_len, cap_cmd}, 48'h0001_20);
    end
  endtask
  task automatic t_blk();
    logic [7:0] c[4] = '{8'h06, 8'h05, 8'h10, 8'h1A};
    logic [7:0] s[4] = '{8'h00, 8'hFE, 8'h02, 8'h05};
    logic [7:0] e[4] = '{8'h00, 8'hFF, 8'h03, 8'h05};
    foreach (c[i]) begin
      st_code = c[i];
      run(ufc_pkg::OP_BLK, 32'h0, s[i], e[i]);
      chk_rsp(r, exp_of(c[i]));
      chk_val({32'h0, cap_len, cap_cmd}, 48'h0007_22);
      chk_val(cap_pay, {s[i], 16'h0000, e[i], 16'hFFFF});
    end
    run(ufc_pkg::OP_BLK, 32'h0, 8'h05, 8'h04);
    chk_val(48'(r.res), 48'(ufc_pkg::RES_BADARG));
  endtask
  task automatic t_tmo();
    silent = 1'b1;
    run(ufc_pkg::OP_CHIP, 32'h0, 8'h00, 8'h00);
    chk_val(48'(r.res), 48'(ufc_pkg::RES_TIMEOUT));
    // the wait starts after five 10-bit bytes of 8 cycles a bit
    chk_val(48'(t >= TO + 400 && t < TO + 500), 48'h1);
    run(ufc_pkg::OP_BLK, 32'h0, 8'h00, 8'h01);
    chk_val(48'(r.res), 48'(ufc_pkg::RES_TIMEOUT));
    chk_val(48'(t >= 2 * TO && t < 2 * TO + 1000), 48'h1);
    run(ufc_pkg::OP_FREQ, 32'h0012_3456, 8'h00, 8'h00);
    chk_val(48'(r.res), 48'(ufc_pkg::RES_TIMEOUT));
    chk_val(48'(fast_rate), 48'h0);
    silent = 1'b0;
  endtask
  task automatic t_hold();
    st_code = 8'h06;
    @(negedge sys_clk);
    req = {ufc_pkg::OP_CHIP, 32'h0, 8'h00, 8'h00};
    req_valid = 1'b1;
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk_val(48'(busy), 48'h0);
    clk_en = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    clk_en = 1'b0;
    repeat (40) @(negedge sys_clk);
    chk_val(48'({busy, txd}), 48'h3);
    clk_en = 1'b1;
    while (done !== 1'b1) @(negedge sys_clk);
    chk_rsp(rsp, exp_of(8'h06));
  endtask
  task automatic t_freq();
    logic [7:0] c[3] = '{8'h05, 8'h07, 8'h06};
    foreach (c[i]) begin
      st_code = c[i];
      run(ufc_pkg::OP_FREQ, 32'hA1B2_C3D4, 8'h00, 8'h00);
      chk_rsp(r, exp_of(c[i]));
      chk_val(48'(fast_rate), 48'h1);
      chk_val({cap_len, cap_cmd, cap_pay[31:0]}, 48'h0590_A1B2_C3D4);
    end
    st_code = 8'h06;
    run(ufc_pkg::OP_CHIP, 32'h0, 8'h00, 8'h00);
    chk_rsp(r, exp_of(8'h06));
  endtask
  initial begin
    {mismatches, n_compared} = '0;
    {nrst, req_valid, silent} = 3'b000;
    clk_en = 1'b1;
    req = '0;
    st_code = 8'h06;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_chip();
    t_hold();
    t_blk();
    t_tmo();
    t_freq();
    conclude();
  end
endmodule
